// ==== hdl/asi_cfg_pkg.sv ====
// constants, types and register layout for the receive channel 8 config block
package asi_cfg_pkg;
   localparam logic [7:0] ADDR_RX_CH8_ROUTING = 8'h2F;
   localparam logic [7:0] ADDR_CLOCK_CONFIG_ZERO = 8'h32;
   localparam logic [7:0] RST_RX_CH8_ROUTING = 8'h07;
   localparam logic [7:0] RST_CLOCK_CONFIG_ZERO = 8'h00;
   localparam int RESERVED_BIT = 7;
   localparam int SRC_MSB = 6;
   localparam int SRC_LSB = 5;
   localparam int SLOT_MSB = 4;
   localparam int SLOT_LSB = 0;
   localparam int RATE_MSB = 7;
   localparam int RATE_LSB = 2;
   localparam int TOL_BIT = 1;
   localparam int CUSTOM_BIT = 0;
   localparam logic [5:0] RATE_AUTO = 6'h00;
   localparam logic [5:0] RATE_LAST = 6'h28;
   localparam logic [4:0] HALF_SLOTS = 5'h10;
   localparam int FRAME_SLOTS = 32;

   typedef enum logic [1:0] {
      SRC_OFF = 2'h0,
      SRC_PLAYBACK = 2'h1,
      SRC_LOOPBACK = 2'h2,
      SRC_LINK = 2'h3
   } src_t;

   typedef enum logic [1:0] {
      FMT_TDM = 2'h0,
      FMT_I2S = 2'h1,
      FMT_LJ = 2'h2
   } fmt_t;

   // one register access from the control interface
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // routing for channel 8 as applied to the frame
   typedef struct packed {
      src_t src;
      logic [4:0] slot;
   } route_t;

   // rate and clock selection summary
   typedef struct packed {
      logic auto_rate;
      logic tol_wide;
      logic custom_clk;
      logic bad_code;
      logic [5:0] code;
   } rate_t;
endpackage

// ==== hdl/asi_rx_slot_and_rate_config.sv ====
// register file and frame-aligned routing for receive channel 8 and rate
`timescale 1ns/1ps

// Notes on behaviour
// - bit 7 of routing register reads zero; only zero may be written
// - source field bits 6-5 resets 0; 0 disables, 1 feeds playback ch8
// - source 2 treats channel 8 as recording channel 4 loopback
// - source 3 treats channel 8 as interchip link device 3 data
// - slot field bits 4-0 resets 7; TDM uses it as slot 0-31
// - I2S/LJ: 0-15 pick left slots, 16-31 pick right slots 0-15
// - rate code bits 7-2 resets 0; zero means automatic rate detect
// - codes 1-40 fix rates 768000 down to 3000 Hz; 41-63 reserved
// - in auto mode bit 1 selects 1% or 5% tolerance
// - bit 0 clear means auto clocking, set means software programs clocks
module asi_rx_slot_and_rate_config import asi_cfg_pkg::*; #(
   parameter int WORD_W = 32
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   input wire fmt_t fmt_in,
   input wire logic frame_start_in,
   input wire logic slot_valid_in,
   input wire logic right_half_in,
   input wire logic [4:0] slot_num_in,
   input wire logic [WORD_W-1:0] slot_data_in,
   output logic [WORD_W-1:0] sample_out,
   output logic [3:0] sample_dest_out,
   output logic sample_valid_out,
   output rate_t rate_out,
   output logic auto_clk_out
);
   logic [7:0] routing;
   logic [7:0] clk_cfg;
   logic [7:0] next_routing;
   logic [7:0] next_clk_cfg;
   logic [7:0] next_rdata;
   route_t active_route;
   route_t next_active_route;
   rate_t next_rate;
   logic next_auto_clk;
   logic [19:0] nominal_hz;
   logic [19:0] floor_hz;

   // nominal frame rate in Hz for each fixed code; zero marks reserved codes
   function automatic logic [19:0] rate_nominal(input logic [5:0] c);
      logic [19:0] r;
      r = 20'h00000;
      case (c)
         6'h01: begin
            r = 20'hBB800;
         end
         6'h02: begin
            r = 20'h96000;
         end
         6'h03: begin
            r = 20'h7D000;
         end
         6'h04: begin
            r = 20'h6B249;
         end
         6'h05: begin
            r = 20'h5DC00;
         end
         6'h06: begin
            r = 20'h53555;
         end
         6'h07: begin
            r = 20'h4B000;
         end
         6'h08: begin
            r = 20'h3E800;
         end
         6'h09: begin
            r = 20'h35925;
         end
         6'h0A: begin
            r = 20'h2EE00;
         end
         6'h0B: begin
            r = 20'h29AAB;
         end
         6'h0C: begin
            r = 20'h25800;
         end
         6'h0D: begin
            r = 20'h1F400;
         end
         6'h0E: begin
            r = 20'h1AC92;
         end
         6'h0F: begin
            r = 20'h17700;
         end
         6'h10: begin
            r = 20'h14D55;
         end
         6'h11: begin
            r = 20'h12C00;
         end
         6'h12: begin
            r = 20'h0FA00;
         end
         6'h13: begin
            r = 20'h0D649;
         end
         6'h14: begin
            r = 20'h0BB80;
         end
         6'h15: begin
            r = 20'h0A6AB;
         end
         6'h16: begin
            r = 20'h09600;
         end
         6'h17: begin
            r = 20'h07D00;
         end
         6'h18: begin
            r = 20'h06B25;
         end
         6'h19: begin
            r = 20'h05DC0;
         end
         6'h1A: begin
            r = 20'h05355;
         end
         6'h1B: begin
            r = 20'h04B00;
         end
         6'h1C: begin
            r = 20'h03E80;
         end
         6'h1D: begin
            r = 20'h03592;
         end
         6'h1E: begin
            r = 20'h02EE0;
         end
         6'h1F: begin
            r = 20'h029AB;
         end
         6'h20: begin
            r = 20'h02580;
         end
         6'h21: begin
            r = 20'h01F40;
         end
         6'h22: begin
            r = 20'h01AC9;
         end
         6'h23: begin
            r = 20'h01770;
         end
         6'h24: begin
            r = 20'h014D5;
         end
         6'h25: begin
            r = 20'h012C0;
         end
         6'h26: begin
            r = 20'h00FA0;
         end
         6'h27: begin
            r = 20'h00D65;
         end
         6'h28: begin
            r = 20'h00BB8;
         end
         default: r = 20'h00000;
      endcase
      return r;
   endfunction

   // lowest accepted rate in Hz for each fixed code; reserved codes give zero
   function automatic logic [19:0] rate_floor(input logic [5:0] c);
      logic [19:0] r;
      r = 20'h00000;
      case (c)
         6'h01: r = 20'hA3A70;
         6'h02: r = 20'h82EC0;
         6'h03: r = 20'h6D1A0;
         6'h04: r = 20'h5D840;
         6'h05: r = 20'h51D38;
         6'h06: r = 20'h48BC0;
         6'h07: r = 20'h41760;
         6'h08: r = 20'h368D0;
         6'h09: r = 20'h2EC20;
         6'h0A: r = 20'h28E9C;
         6'h0B: r = 20'h245E0;
         6'h0C: r = 20'h20BB0;
         6'h0D: r = 20'h1B468;
         6'h0E: r = 20'h17610;
         6'h0F: r = 20'h1474E;
         6'h10: r = 20'h122F0;
         6'h11: r = 20'h105D8;
         6'h12: r = 20'h0DA34;
         6'h13: r = 20'h0BB08;
         6'h14: r = 20'h0A3A7;
         6'h15: r = 20'h09178;
         6'h16: r = 20'h082EC;
         6'h17: r = 20'h06D1A;
         6'h18: r = 20'h05D84;
         6'h19: r = 20'h051D3;
         6'h1A: r = 20'h048BC;
         6'h1B: r = 20'h04176;
         6'h1C: r = 20'h0368D;
         6'h1D: r = 20'h02EC2;
         6'h1E: r = 20'h028E9;
         6'h1F: r = 20'h0245E;
         6'h20: r = 20'h020BB;
         6'h21: r = 20'h01B46;
         6'h22: r = 20'h01761;
         6'h23: r = 20'h01474;
         6'h24: r = 20'h0122F;
         6'h25: r = 20'h0105D;
         6'h26: r = 20'h00DA3;
         6'h27: r = 20'h00BB0;
         6'h28: r = 20'h00A3A;
         default: r = 20'h00000;
      endcase
      return r;
   endfunction

   // register writes; reserved bit is forced to zero on store
   always_comb begin
      next_routing = routing;
      next_clk_cfg = clk_cfg;
      if (reg_req_in.wr) begin
         case (reg_req_in.addr)
            ADDR_RX_CH8_ROUTING: begin
               next_routing = reg_req_in.wdata;
               next_routing[RESERVED_BIT] = 1'b0;
            end
            ADDR_CLOCK_CONFIG_ZERO: next_clk_cfg = reg_req_in.wdata;
            default: next_routing = routing;
         endcase
      end
   end

   // read data registered; unmapped addresses read zero
   always_comb begin
      next_rdata = reg_rdata_out;
      if (reg_req_in.rd) begin
         case (reg_req_in.addr)
            ADDR_RX_CH8_ROUTING: next_rdata = {1'b0, routing[6:0]};
            ADDR_CLOCK_CONFIG_ZERO: next_rdata = clk_cfg;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         routing <= RST_RX_CH8_ROUTING;
         clk_cfg <= RST_CLOCK_CONFIG_ZERO;
         reg_rdata_out <= 8'h00;
      end else begin
         routing <= next_routing;
         clk_cfg <= next_clk_cfg;
         reg_rdata_out <= next_rdata;
      end
   end

   // shadow copy: a mid-frame write would split a sample across two slots
   always_comb begin
      next_active_route = active_route;
      if (frame_start_in) begin
         next_active_route.src = src_t'(routing[SRC_MSB:SRC_LSB]);
         next_active_route.slot = routing[SLOT_MSB:SLOT_LSB];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         active_route <= route_t'(7'h07);
      end else begin
         active_route <= next_active_route;
      end
   end

   // rate decode; reserved codes flagged rather than silently used
   always_comb begin
      next_rate.code = clk_cfg[RATE_MSB:RATE_LSB];
      nominal_hz = rate_nominal(next_rate.code);
      floor_hz = rate_floor(next_rate.code);
      next_rate.auto_rate = (next_rate.code == RATE_AUTO);
      // a fixed code must name a rate above its floor; reserved ones do not
      next_rate.bad_code = !next_rate.auto_rate &&
         (next_rate.code > RATE_LAST || floor_hz >= nominal_hz);
      // tolerance only matters while detecting automatically
      next_rate.tol_wide = next_rate.auto_rate && clk_cfg[TOL_BIT];
      next_rate.custom_clk = clk_cfg[CUSTOM_BIT];
      next_auto_clk = !clk_cfg[CUSTOM_BIT];
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rate_out <= '0;
         auto_clk_out <= 1'b1;
      end else begin
         rate_out <= next_rate;
         auto_clk_out <= next_auto_clk;
      end
   end

   rx_ch8_slot_capture #(
      .WORD_W(WORD_W)
   ) u_capture (
      .sys_clk_in(sys_clk_in),
      .rst_b_in(rst_b_in),
      .route_in(active_route),
      .fmt_in(fmt_in),
      .slot_valid_in(slot_valid_in),
      .right_half_in(right_half_in),
      .slot_num_in(slot_num_in),
      .slot_data_in(slot_data_in),
      .sample_out(sample_out),
      .sample_dest_out(sample_dest_out),
      .sample_valid_out(sample_valid_out)
   );
endmodule

// ==== hdl/rx_ch8_slot_capture.sv ====
// slot matcher that captures the channel 8 sample from the serial frame
`timescale 1ns/1ps
module rx_ch8_slot_capture import asi_cfg_pkg::*; #(
   parameter int WORD_W = 32
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire route_t route_in,
   input wire fmt_t fmt_in,
   input wire logic slot_valid_in,
   input wire logic right_half_in,
   input wire logic [4:0] slot_num_in,
   input wire logic [WORD_W-1:0] slot_data_in,
   output logic [WORD_W-1:0] sample_out,
   output logic [3:0] sample_dest_out,
   output logic sample_valid_out
);
   logic [WORD_W-1:0] next_sample;
   logic [3:0] next_dest;
   logic next_valid;
   logic hit;

   // true when the incoming slot is the one channel 8 listens to
   function automatic logic slot_match(input route_t r, input fmt_t f,
         input logic rh, input logic [4:0] n);
      logic m;
      m = 1'b0;
      if (f == FMT_TDM) begin
         m = (n == r.slot);
      end else begin
         // left/right halves each carry 16 slots
         m = (rh == (r.slot >= HALF_SLOTS)) && (n[3:0] == r.slot[3:0]);
      end
      return m;
   endfunction

   // destination one-hot: playback, loopback, link; off captures nothing
   always_comb begin
      hit = slot_valid_in && slot_match(route_in, fmt_in, right_half_in,
         slot_num_in);
      next_sample = sample_out;
      next_dest = sample_dest_out;
      next_valid = 1'b0;
      if (hit && route_in.src != SRC_OFF) begin
         next_sample = slot_data_in;
         next_valid = 1'b1;
         case (route_in.src)
            SRC_PLAYBACK: next_dest = 4'h1;
            SRC_LOOPBACK: next_dest = 4'h2;
            SRC_LINK: next_dest = 4'h4;
            default: next_dest = 4'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sample_out <= '0;
         sample_dest_out <= 4'h0;
         sample_valid_out <= 1'b0;
      end else begin
         sample_out <= next_sample;
         sample_dest_out <= next_dest;
         sample_valid_out <= next_valid;
      end
   end
endmodule

// ==== tb/rx_ch8_properties.sv ====
// port assertions for the channel 8 routing and clock config block
`timescale 1ns/1ps
module rx_ch8_properties import asi_cfg_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire reg_req_t reg_req_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic slot_valid_in,
   input wire logic [3:0] sample_dest_out,
   input wire logic sample_valid_out,
   input wire rate_t rate_out,
   input wire logic auto_clk_out
);
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   logic cw;
   logic [7:0] d;
   // clock config write strobe and its data
   assign cw = reg_req_in.wr && reg_req_in.addr == ADDR_CLOCK_CONFIG_ZERO;
   assign d = reg_req_in.wdata;
   // outputs follow the stored register one edge after the write edge
   a_auto_clk: assert property (cw |-> ##2 auto_clk_out == !$past(d[0], 2))
      else $error("auto clock flag wrong");
   a_custom_bit: assert property (cw |-> ##2 rate_out.custom_clk == $past(d[0], 2))
      else $error("custom clock flag wrong");
   a_rate_code: assert property (cw |-> ##2 rate_out.code == $past(d[7:2], 2) &&
      rate_out.auto_rate == ($past(d[7:2], 2) == 6'h00))
      else $error("rate code wrong");
   a_bad_code: assert property (cw |-> ##2
      rate_out.bad_code == ($past(d[7:2], 2) > 6'h28))
      else $error("reserved code flag wrong");
   a_tol_sel: assert property (cw |-> ##2 rate_out.tol_wide ==
      ($past(d[1], 2) && $past(d[7:2], 2) == 6'h00))
      else $error("tolerance select wrong");
   a_rsvd_zero: assert property (reg_req_in.rd &&
      reg_req_in.addr == ADDR_RX_CH8_ROUTING |=> !reg_rdata_out[7])
      else $error("reserved bit reads one");
   a_valid_cause: assert property (sample_valid_out |-> $past(slot_valid_in))
      else $error("sample without slot");
   a_dest_onehot: assert property (sample_valid_out |-> $onehot(sample_dest_out))
      else $error("destination not one-hot");
   c_capture: cover property (sample_valid_out);
   c_bad: cover property (cw && d[7:2] > 6'h28);
   c_wide: cover property (cw && d == 8'h02);
endmodule
bind asi_rx_slot_and_rate_config rx_ch8_properties i_rx_ch8_properties (
   .sys_clk_in, .rst_b_in, .reg_req_in, .reg_rdata_out, .slot_valid_in,
   .sample_dest_out, .sample_valid_out, .rate_out, .auto_clk_out);

// ==== tb/slot_host.sv ====
// host port model: one frame of 32 slots per go pulse
`timescale 1ns/1ps
module slot_host import asi_cfg_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic go_in,
   input wire fmt_t fmt_in,
   output logic frame_start_out = 1'b0,
   output logic slot_valid_out = 1'b0,
   output logic right_half_out = 1'b0,
   output logic [4:0] slot_num_out = 5'h00,
   output logic [31:0] slot_data_out = 32'h0,
   output logic busy_out
);
   int k = 0;
   assign busy_out = k != 0;
   // idle data toggles so a stale capture never looks right
   always @(posedge sys_clk_in) begin
      frame_start_out <= go_in && k == 0;
      slot_valid_out <= k > 0 && k < 33;
      slot_data_out <= ~slot_data_out;
      if (k > 0 && k < 33) begin
         slot_num_out <= (fmt_in == FMT_TDM) ? 5'(k - 1) : 5'((k - 1) % 16);
         right_half_out <= fmt_in != FMT_TDM && k > 16;
         slot_data_out <= {8'hA5, 19'h0, 5'(k - 1)};
      end
      k <= (k == 33) ? 0 : (k > 0 || go_in) ? k + 1 : 0;
   end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the channel 8 routing and clock config block
`timescale 1ns/1ps
module testbench import asi_cfg_pkg::*;;
   logic sys_clk_in = 1'b0, rst_b_in = 1'b0, go = 1'b0;
   reg_req_t req = '0;
   fmt_t fmt = FMT_TDM;
   logic fs, sv, rh, val, aclk, busy;
   logic [4:0] sn;
   logic [31:0] sd, so, cap_d;
   logic [3:0] dst, cap_dst;
   logic [7:0] rdata, cur, lf = 8'h50;
   rate_t rate;
   int error_cnt = 0, n_compared = 0, cyc = 0, cap_n = 0;
   asi_rx_slot_and_rate_config i_asi_rx_slot_and_rate_config (
      .sys_clk_in, .rst_b_in, .reg_req_in(req), .reg_rdata_out(rdata),
      .fmt_in(fmt), .frame_start_in(fs), .slot_valid_in(sv),
      .right_half_in(rh), .slot_num_in(sn), .slot_data_in(sd),
      .sample_out(so), .sample_dest_out(dst), .sample_valid_out(val),
      .rate_out(rate), .auto_clk_out(aclk));
   slot_host i_slot_host (.sys_clk_in, .go_in(go), .fmt_in(fmt),
      .frame_start_out(fs), .slot_valid_out(sv), .right_half_out(rh),
      .slot_num_out(sn), .slot_data_out(sd), .busy_out(busy));
   always #5 sys_clk_in = ~sys_clk_in;
   task automatic print_verdict();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic rate_t exp_rate(input logic [7:0] d);
      return '{d[7:2] == 6'h00, d[1] && d[7:2] == 6'h00, d[0],
         d[7:2] > 6'h28, d[7:2]};
   endfunction
   // one-cycle register strobe, released after the taking edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_in) #1;
      req = '{w, !w, a, d};
      @(posedge sys_clk_in) #1;
      req = '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(32'(rdata), 32'(exp));
   endtask
   // one frame; an optional routing write lands mid-frame
   task automatic run(input logic mid, input logic [7:0] nxt);
      cap_n = 0;
      @(posedge sys_clk_in) #1;
      go = 1'b1;
      @(posedge sys_clk_in) #1;
      go = 1'b0;
      if (mid) begin
         repeat (3) @(posedge sys_clk_in);
         acc(1'b1, ADDR_RX_CH8_ROUTING, nxt);
      end
      for (int i = 0; i < 50 && busy; i++) @(posedge sys_clk_in);
      repeat (3) @(posedge sys_clk_in);
      #1;
      chk(cap_n, 32'(cur[6:5] != 2'h0));
      if (cur[6:5] != 2'h0) begin
         chk(cap_d, {8'hA5, 19'h0, cur[4:0]});
         chk(32'(cap_dst), 32'(4'h1 << (cur[6:5] - 2'h1)));
      end
      if (mid)
         cur = nxt;
   endtask
   // sample monitor and hang guard
   always @(posedge sys_clk_in) begin
      cyc++;
      if (val === 1'b1) begin
         cap_n++;
         cap_d = so;
         cap_dst = dst;
      end
      if (cyc > 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      logic [7:0] d;
      repeat (2) @(posedge sys_clk_in);
      #1 rst_b_in = 1'b1;
      rd(ADDR_RX_CH8_ROUTING, 8'h07);
      rd(ADDR_CLOCK_CONFIG_ZERO, 8'h00);
      chk(32'(aclk), 32'h1);
      for (int i = 0; i < 12; i++) begin
         lf = lfsr(lf);
         d = (i == 0) ? 8'h02 : (i == 1) ? 8'hA1 : (i == 2) ? 8'hA4 : lf;
         acc(1'b1, ADDR_CLOCK_CONFIG_ZERO, d);
         rd(ADDR_CLOCK_CONFIG_ZERO, d);
         // decoded outputs trail the stored byte by one edge
         chk(32'(rate), 32'(exp_rate(d)));
         chk(32'(aclk), 32'(!d[0]));
      end
      for (int i = 0; i < 12; i++) begin
         lf = lfsr(lf);
         fmt = fmt_t'(i % 3);
         cur = {1'b0, 2'(i % 4), (i == 1) ? 5'h1F : (i == 2) ? 5'h10 : lf[4:0]};
         acc(1'b1, ADDR_RX_CH8_ROUTING, cur | 8'h80);
         rd(ADDR_RX_CH8_ROUTING, cur);
         run(1'b0, 8'h00);
      end
      run(1'b1, 8'h3F);
      run(1'b0, 8'h00);
      print_verdict();
   end
endmodule
